/* include/scbu_consts.svh */
// constants of the scalar crypto and bit-manipulation unit
// assumes nothing beyond a SystemVerilog compiler
`ifndef SCBU_CONSTS_SVH
`define SCBU_CONSTS_SVH
`define XLEN 64
`define WORD_W 32
`define OP_W 4
`define REG_IDX_W 5
`define RNUM_W 4
`define RNUM_MAX 4'hA
`define RNUM_NOROT 4'hA
`define KS_ROT 8
`define GF_POLY 8'h1B
`define SBOX_AFFINE 8'h63
`define IMC_E 8'h0E
`define IMC_B 8'h0B
`define IMC_D 8'h0D
`define IMC_9 8'h09
`define RESULT_LATENCY 1
`endif

/* include/scbu_pkg.sv */
// types of the scalar crypto and bit-manipulation unit
// assumes the constants header is on the include path
`include "scbu_consts.svh"
package scbu_pkg;
   typedef enum logic [`OP_W-1:0] {
      OP_NONE = 4'h0,
      OP_AES_INV_MIX = 4'h1,
      OP_AES_KS_SUB = 4'h2,
      OP_AES_KS_XOR = 4'h3,
      OP_AND_NOT = 4'h4,
      OP_OR_NOT = 4'h5,
      OP_BIT_REV_BYTE = 4'h6,
      OP_CLMUL_LO = 4'h7,
      OP_CLMUL_HI = 4'h8,
      OP_PACK = 4'h9,
      OP_PACK_BYTE = 4'hA,
      OP_PACK_WORD = 4'hB,
      OP_BYTE_REV = 4'hC
   } op_t;

   typedef struct packed {
      logic resValid;
      logic resWrite;
      logic illegal;
      logic [`REG_IDX_W-1:0] dest;
      logic [`XLEN-1:0] data;
   } unit_state_t;
endpackage

/* rtl/scalar_crypto_bitmanip_unit.sv */
// scalar crypto and bit-manipulation execution unit, one registered stage
// assumes decode presents one operation per cycle with operands already read
`timescale 1ns/1ps
module scalar_crypto_bitmanip_unit
   import scbu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic opValid,
   input wire op_t opCode,
   input wire logic [`XLEN-1:0] srcA,
   input wire logic [`XLEN-1:0] srcB,
   input wire logic [`RNUM_W-1:0] roundNum,
   input wire logic [`REG_IDX_W-1:0] destIdx,
   input wire logic aesDecEn,
   input wire logic aesEncEn,
   input wire logic bitmanipEn,
   input wire logic clmulEn,
   input wire logic narrowMode,
   output logic resValid,
   output logic resWrite,
   output logic [`REG_IDX_W-1:0] resDest,
   output logic [`XLEN-1:0] resData,
   output logic illegalInstr
);

   unit_state_t state_q;
   unit_state_t state_d;

   // multiply in the AES field
   function automatic logic [7:0] gfMul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] acc;
      logic [7:0] sh;
      acc = 8'h00;
      sh = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            acc = acc ^ sh;
         end
         sh = sh[7] ? ({sh[6:0], 1'b0} ^ `GF_POLY) : {sh[6:0], 1'b0};
      end
      return acc;
   endfunction

   // forward S-box: field inverse by x^254, then affine map
   function automatic logic [7:0] sboxFwd(input logic [7:0] x);
      logic [7:0] p;
      logic [7:0] r;
      logic [7:0] s;
      p = x;
      r = 8'h01;
      for (int i = 0; i < 7; i++) begin
         p = gfMul(p, p);
         r = gfMul(r, p);
      end
      s = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]};
      return s ^ `SBOX_AFFINE;
   endfunction

   // inverse mix of one column, byte 0 in the low bits
   function automatic logic [`WORD_W-1:0] invMixCol(input logic [`WORD_W-1:0] c);
      logic [7:0] a [4];
      logic [`WORD_W-1:0] o;
      o = '0;
      for (int k = 0; k < 4; k++) begin
         a[k] = c[8*k +: 8];
      end
      for (int k = 0; k < 4; k++) begin
         o[8*k +: 8] = gfMul(a[k], `IMC_E) ^ gfMul(a[(k+1)%4], `IMC_B)
                     ^ gfMul(a[(k+2)%4], `IMC_D) ^ gfMul(a[(k+3)%4], `IMC_9);
      end
      return o;
   endfunction

   // round number to round constant, 0xA gives zero
   function automatic logic [7:0] roundConst(input logic [`RNUM_W-1:0] n);
      logic [7:0] rc;
      unique case (n)
         4'h0: rc = 8'h01;
         4'h1: rc = 8'h02;
         4'h2: rc = 8'h04;
         4'h3: rc = 8'h08;
         4'h4: rc = 8'h10;
         4'h5: rc = 8'h20;
         4'h6: rc = 8'h40;
         4'h7: rc = 8'h80;
         4'h8: rc = 8'h1B;
         4'h9: rc = 8'h36;
         default: rc = 8'h00;
      endcase
      return rc;
   endfunction

   // full carry-less product, fixed-length loop
   function automatic logic [2*`XLEN-1:0] clmulFull(input logic [`XLEN-1:0] a, input logic [`XLEN-1:0] b);
      logic [2*`XLEN-1:0] acc;
      acc = '0;
      for (int i = 0; i < `XLEN; i++) begin
         if (b[i]) begin
            acc = acc ^ ({{`XLEN{1'b0}}, a} << i);
         end
      end
      return acc;
   endfunction

   // bits reversed inside every byte, bytes kept in place
   function automatic logic [`XLEN-1:0] revBitsInBytes(input logic [`XLEN-1:0] x);
      logic [`XLEN-1:0] r;
      r = '0;
      for (int i = 0; i < `XLEN; i += 8) begin
         for (int j = 0; j < 8; j++) begin
            r[i+j] = x[i+7-j];
         end
      end
      return r;
   endfunction

   // byte order reversed over the full register
   function automatic logic [`XLEN-1:0] revBytes(input logic [`XLEN-1:0] x);
      logic [`XLEN-1:0] r;
      r = '0;
      for (int i = 0; i < `XLEN; i += 8) begin
         r[i +: 8] = x[`XLEN-8-i +: 8];
      end
      return r;
   endfunction

   // forward S-box on each byte of a word
   function automatic logic [`WORD_W-1:0] subWord(input logic [`WORD_W-1:0] w);
      logic [`WORD_W-1:0] r;
      r = '0;
      for (int k = 0; k < 4; k++) begin
         r[8*k +: 8] = sboxFwd(w[8*k +: 8]);
      end
      return r;
   endfunction

   // rotate right by one byte unless last round
   function automatic logic [`WORD_W-1:0] ksRotate(input logic [`WORD_W-1:0] w, input logic [`RNUM_W-1:0] n);
      return (n == `RNUM_NOROT) ? w : {w[`KS_ROT-1:0], w[`WORD_W-1:`KS_ROT]};
   endfunction

   // round constant widened to a word
   function automatic logic [`WORD_W-1:0] rconWord(input logic [`RNUM_W-1:0] n);
      return {24'h000000, roundConst(n)};
   endfunction

   // one word copied into both halves
   function automatic logic [`XLEN-1:0] ksBothHalves(input logic [`WORD_W-1:0] w);
      return {w, w};
   endfunction

   // key-schedule word xor
   function automatic logic [`XLEN-1:0] ksXorWords(input logic [`XLEN-1:0] a, input logic [`XLEN-1:0] b);
      logic [`WORD_W-1:0] lo;
      lo = a[`XLEN-1:`WORD_W] ^ b[`WORD_W-1:0];
      return {lo ^ b[`XLEN-1:`WORD_W], lo};
   endfunction

   // inverse mix on both packed columns
   function automatic logic [`XLEN-1:0] invMix64(input logic [`XLEN-1:0] x);
      return {invMixCol(x[`XLEN-1:`WORD_W]), invMixCol(x[`WORD_W-1:0])};
   endfunction

   // low halves joined
   function automatic logic [`XLEN-1:0] packHalves(input logic [`XLEN-1:0] a, input logic [`XLEN-1:0] b);
      return {b[`WORD_W-1:0], a[`WORD_W-1:0]};
   endfunction

   // low bytes joined, upper bits cleared
   function automatic logic [`XLEN-1:0] packByteZero(input logic [`XLEN-1:0] a, input logic [`XLEN-1:0] b);
      return {48'h000000000000, b[7:0], a[7:0]};
   endfunction

   // low 16-bit parts joined, sign-extended
   function automatic logic [`XLEN-1:0] packWordExt(input logic [`XLEN-1:0] a, input logic [`XLEN-1:0] b);
      return {{`WORD_W{b[15]}}, b[15:0], a[15:0]};
   endfunction

   // and with inverted second source
   function automatic logic [`XLEN-1:0] andNot(input logic [`XLEN-1:0] a, input logic [`XLEN-1:0] b);
      return a & ~b;
   endfunction

   // or with inverted second source
   function automatic logic [`XLEN-1:0] orNot(input logic [`XLEN-1:0] a, input logic [`XLEN-1:0] b);
      return a | ~b;
   endfunction

   logic [`WORD_W-1:0] ksWord;
   logic [`WORD_W-1:0] ksSub;
   logic [2*`XLEN-1:0] clProd;
   logic [`XLEN-1:0] bitRev;
   logic [`XLEN-1:0] byteRev;
   logic [`XLEN-1:0] result;
   logic opIllegal;

   always_comb begin
      ksWord = ksRotate(srcA[`XLEN-1:`WORD_W], roundNum);
      ksSub = subWord(ksWord) ^ rconWord(roundNum);
      clProd = clmulFull(srcA, srcB);
      bitRev = revBitsInBytes(srcA);
      byteRev = revBytes(srcA);
   end

   // fixed-path result select; all arms computed every cycle
   always_comb begin
      opIllegal = 1'b0;
      result = '0;
      unique case (opCode)
         OP_AES_INV_MIX: begin
            result = invMix64(srcA);
            opIllegal = !aesDecEn;
         end
         OP_AES_KS_SUB: begin
            result = ksBothHalves(ksSub);
            opIllegal = (roundNum > `RNUM_MAX) || !(aesEncEn || aesDecEn);
         end
         OP_AES_KS_XOR: begin
            result = ksXorWords(srcA, srcB);
            opIllegal = !(aesEncEn || aesDecEn);
         end
         OP_AND_NOT: begin
            result = andNot(srcA, srcB);
            opIllegal = !bitmanipEn;
         end
         OP_OR_NOT: begin
            result = orNot(srcA, srcB);
            opIllegal = !bitmanipEn;
         end
         OP_BIT_REV_BYTE: begin
            result = bitRev;
            opIllegal = !bitmanipEn;
         end
         OP_CLMUL_LO: begin
            result = clProd[`XLEN-1:0];
            opIllegal = !clmulEn;
         end
         OP_CLMUL_HI: begin
            result = clProd[2*`XLEN-1:`XLEN];
            opIllegal = !clmulEn;
         end
         OP_PACK: begin
            result = packHalves(srcA, srcB);
            opIllegal = !bitmanipEn;
         end
         OP_PACK_BYTE: begin
            result = packByteZero(srcA, srcB);
            opIllegal = !bitmanipEn;
         end
         OP_PACK_WORD: begin
            result = packWordExt(srcA, srcB);
            opIllegal = !bitmanipEn || narrowMode;
         end
         OP_BYTE_REV: begin
            result = byteRev;
            opIllegal = !bitmanipEn;
         end
         default: begin
            opIllegal = 1'b1;
         end
      endcase
   end

   always_comb begin
      state_d.resValid = opValid;
      state_d.illegal = opValid && opIllegal;
      state_d.resWrite = opValid && !opIllegal && (destIdx != 5'h00);
      state_d.dest = destIdx;
      state_d.data = (opValid && !opIllegal) ? result : '0;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign resValid = state_q.resValid;
   assign resWrite = state_q.resWrite;
   assign resDest = state_q.dest;
   assign resData = state_q.data;
   assign illegalInstr = state_q.illegal;

endmodule

/* testbench/regfile_model.sv */
// integer register file taking unit results
// assumes results arrive one per cycle
`timescale 1ns/1ps
`include "scbu_consts.svh"
module regfile_model (
   input wire logic ref_clk,
   input wire logic resValid,
   input wire logic resWrite,
   input wire logic [`REG_IDX_W-1:0] resDest,
   input wire logic [`XLEN-1:0] resData
);
   logic [`XLEN-1:0] regs [32] = '{default: 64'h0};
   always @(posedge ref_clk) if (resValid && resWrite) regs[resDest] <= resData;
endmodule

/* testbench/scbu_asserts.sv */
// port assertions for the crypto and bit-manipulation unit
// assumes a bind from the bench top
`timescale 1ns/1ps
`include "scbu_consts.svh"
module scbu_asserts
   import scbu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic opValid,
   input wire op_t opCode,
   input wire logic [`XLEN-1:0] srcA,
   input wire logic [`XLEN-1:0] srcB,
   input wire logic [`RNUM_W-1:0] roundNum,
   input wire logic [`REG_IDX_W-1:0] destIdx,
   input wire logic aesDecEn,
   input wire logic aesEncEn,
   input wire logic bitmanipEn,
   input wire logic clmulEn,
   input wire logic narrowMode,
   input wire logic resValid,
   input wire logic resWrite,
   input wire logic [`REG_IDX_W-1:0] resDest,
   input wire logic [`XLEN-1:0] resData,
   input wire logic illegalInstr
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   a_one_cycle: assert property (opValid |=> resValid)
      else $error("late result");
   a_idle_quiet: assert property (!opValid |=> !resValid && resData == 64'h0)
      else $error("stray result");
   a_ks_reserved: assert property (opValid && opCode == OP_AES_KS_SUB && roundNum > 4'hA |=> illegalInstr)
      else $error("reserved round");
   a_ks_halves: assert property (opValid && opCode == OP_AES_KS_SUB |=> resData[63:32] == resData[31:0])
      else $error("halves differ");
   a_andn_value: assert property (opValid && opCode == OP_AND_NOT && bitmanipEn |=>
      resData == ($past(srcA) & ~$past(srcB))) else $error("and-not");
   a_orn_value: assert property (opValid && opCode == OP_OR_NOT && bitmanipEn |=>
      resData == ($past(srcA) | ~$past(srcB))) else $error("or-not");
   a_packb_clear: assert property (opValid && opCode == OP_PACK_BYTE |=> resData[63:16] == 48'h0)
      else $error("pack-byte");
   a_packw_narrow: assert property (opValid && opCode == OP_PACK_WORD && narrowMode |=> illegalInstr)
      else $error("pack-word narrow");
   a_dest_zero: assert property (opValid && destIdx == 5'h0 |=> !resWrite)
      else $error("zero dest written");
   cover property (opValid && opCode == OP_AES_KS_SUB && roundNum == 4'hA);
   cover property (resValid && illegalInstr);
   cover property (resValid && resWrite);
endmodule

/* testbench/testbench.sv */
// self-checking bench for the crypto and bit-manipulation unit
// assumes unit, checker and register file model compiled first
`timescale 1ns/1ps
`include "scbu_consts.svh"
module testbench
   import scbu_pkg::*;
;
   logic ref_clk = 1'b0, reset_n = 1'b0, opValid = 1'b0;
   op_t opCode = OP_NONE;
   logic [63:0] srcA = 64'h0, srcB = 64'h0, resData, s = 64'd53;
   logic [3:0] roundNum = 4'h0;
   logic [4:0] destIdx = 5'h0, resDest;
   logic aesDecEn = 1'b0, aesEncEn = 1'b0, bitmanipEn = 1'b0, clmulEn = 1'b0, narrowMode = 1'b0;
   logic resValid, resWrite, illegalInstr;
   logic [69:0] expQ [$];
   logic [69:0] curE;
   logic [63:0] shadow [32] = '{default: 64'h0};
   int n_mismatch = 0;
   int tests_run = 0;
   always #5 ref_clk = ~ref_clk;
   scalar_crypto_bitmanip_unit u_scalar_crypto_bitmanip_unit(.ref_clk, .reset_n, .opValid, .opCode, .srcA,
      .srcB, .roundNum, .destIdx, .aesDecEn, .aesEncEn, .bitmanipEn, .clmulEn, .narrowMode, .resValid,
      .resWrite, .resDest, .resData, .illegalInstr);
   regfile_model u_regfile_model(.ref_clk, .resValid, .resWrite, .resDest, .resData);
   function automatic logic [63:0] rnd(input logic [63:0] x);
      repeat (64) x = {x[62:0], x[63] ^ x[62] ^ x[60] ^ x[59]};
      return x;
   endfunction
   function automatic logic [7:0] gm(input logic [7:0] a, input logic [3:0] k);
      logic [7:0] r;
      r = 8'h0;
      for (int i = 0; i < 4; i++) begin
         if (k[i]) r ^= a;
         a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
      end
      return r;
   endfunction
   function automatic logic [31:0] imc(input logic [31:0] w);
      logic [31:0] r;
      for (int i = 0; i < 4; i++) r[8*i+:8] = gm(w[8*i+:8], 4'hE) ^ gm(w[8*((i+1)%4)+:8], 4'hB)
         ^ gm(w[8*((i+2)%4)+:8], 4'hD) ^ gm(w[8*((i+3)%4)+:8], 4'h9);
      return r;
   endfunction
   function automatic logic [63:0] model(input op_t op, input logic [63:0] a, input logic [63:0] b);
      logic [127:0] p;
      logic [63:0] r;
      p = 128'h0;
      for (int i = 0; i < 64; i++) if (b[i]) p ^= {64'h0, a} << i;
      case (op)
         OP_AES_INV_MIX: r = {imc(a[63:32]), imc(a[31:0])};
         OP_AES_KS_XOR: r = {a[63:32] ^ b[31:0] ^ b[63:32], a[63:32] ^ b[31:0]};
         OP_AND_NOT: r = a & ~b;
         OP_OR_NOT: r = a | ~b;
         OP_CLMUL_LO: r = p[63:0];
         OP_CLMUL_HI: r = p[127:64];
         OP_PACK: r = {b[31:0], a[31:0]};
         OP_PACK_BYTE: r = {48'h0, b[7:0], a[7:0]};
         OP_PACK_WORD: r = {{32{b[15]}}, b[15:0], a[15:0]};
         default: for (int i = 0; i < 64; i++)
            r[i] = a[op == OP_BYTE_REV ? 56 - (i & 56) + (i & 7) : (i & 56) + 7 - (i & 7)];
      endcase
      return r;
   endfunction
   task automatic drive(input op_t op, input logic [63:0] a, input logic [63:0] b, input logic [3:0] rn,
      input logic [4:0] d, input logic [4:0] e);
      logic ok;
      logic [7:0] rc;
      logic [31:0] w;
      rc = 8'h01;
      repeat (rn) rc = gm(rc, 4'h2);
      w = rn == 4'hA ? 32'h63636300 : 32'h00636363 ^ {24'h0, rc};
      if (op == OP_AES_KS_SUB) a[63:32] = 32'h52;
      case (op)
         OP_AES_INV_MIX: ok = e[0];
         OP_AES_KS_SUB: ok = |e[1:0] && rn <= 4'hA;
         OP_AES_KS_XOR: ok = |e[1:0];
         OP_CLMUL_LO, OP_CLMUL_HI: ok = e[3];
         OP_PACK_WORD: ok = e[2] && !e[4];
         default: ok = e[2];
      endcase
      if (op == OP_NONE || op > OP_BYTE_REV) ok = 1'b0;
      @(posedge ref_clk);
      {opValid, opCode, srcA, srcB, roundNum, destIdx} <= {1'b1, op, a, b, rn, d};
      {narrowMode, clmulEn, bitmanipEn, aesEncEn, aesDecEn} <= e;
      expQ.push_back({ok, d, !ok ? 64'h0 : op == OP_AES_KS_SUB ? {w, w} : model(op, a, b)});
   endtask
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
      tests_run++;
      if (seen !== want) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask
   task give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      #1;
      if (resValid === 1'b1) begin
         check("expected", 64'(expQ.size() > 0), 64'h1);
         curE = expQ.size() > 0 ? expQ.pop_front() : 70'h0;
         check("illegal", 64'(illegalInstr), 64'(!curE[69]));
         check("write", 64'(resWrite), 64'(curE[69] && curE[68:64] != 5'h0));
         check("dest", 64'(resDest), 64'(curE[68:64]));
         check("data", resData, curE[63:0]);
         if (curE[69] && curE[68:64] != 5'h0) shadow[curE[68:64]] = curE[63:0];
      end
   end
   initial begin
      #300000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3000) begin
         s = rnd(s);
         drive(op_t'(s[24:22] == 3'h0 ? s[3:0] : s[3:0] % 4'hC + 4'h1), rnd(s), rnd(rnd(s)), s[7:4], s[12:8],
            s[15:13] == 3'h0 ? s[20:16] : 5'h0F);
      end
      @(posedge ref_clk);
      opValid <= 1'b0;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 32; i++) check("regfile", u_regfile_model.regs[i], shadow[i]);
      check("pending", 64'(expQ.size()), 64'h0);
      give_verdict();
   end
endmodule
bind scalar_crypto_bitmanip_unit scbu_asserts u_scbu_asserts(.ref_clk, .reset_n, .opValid, .opCode, .srcA,
   .srcB, .roundNum, .destIdx, .aesDecEn, .aesEncEn, .bitmanipEn, .clmulEn, .narrowMode, .resValid,
   .resWrite, .resDest, .resData, .illegalInstr);
